/* core/reset_seq_pkg.sv */
// Functional notes
// - monitor on, clock bad after delays: trap
// - trap switches system clock to fast RC
// - monitor and power-up timer off: fast exit
// - fast exit: non-crystal sources run immediately
// - monitor off, no clock: frozen in reset
// - brownout issues whole-device reset pulse
// - three selectable brownout trip levels
// - brownout picks clock from config fields
// - crystal: startup timer holds clock after brownout
// - pll in use: hold clock until lock
// - power-on and power-up delays run back to back
// - no power-up delay, crystal, monitor on: add fail-safe delay
// - brownout sets reset control bit 1
// - brownout detection active in sleep and idle
// - trap: load fast RC, set flag, clear go
// - monitor config 1x disables switching and monitor
// - reset loads current and new group from config
package reset_seq_pkg;

   // ======================================================
   // register map
   localparam int unsigned   ADDR_W       = 8;
   localparam logic [7:0]    RST_CTRL_OFF = 8'h00;
   localparam logic [7:0]    OSC_CTRL_OFF = 8'h04;
   localparam logic [7:0]    CFG_OFF      = 8'h08;
   localparam logic [7:0]    IRQ_STAT_OFF = 8'h0C;
   localparam logic [7:0]    IRQ_CLR_OFF  = 8'h10;
   localparam logic [7:0]    IRQ_EN_OFF   = 8'h14;
   localparam logic [1:0]    RESP_OKAY    = 2'h0;
   localparam logic [1:0]    RESP_SLVERR  = 2'h2;

   // ======================================================
   // field positions
   localparam int unsigned   POR_FLAG_BIT = 0;
   localparam int unsigned   BOR_FLAG_BIT = 1;
   localparam int unsigned   OSC_SWITCH_GO_BIT    = 0;
   localparam int unsigned   CF_BIT       = 3;
   localparam int unsigned   LOCK_BIT     = 5;
   localparam int unsigned   NOSC_LSB     = 8;
   localparam int unsigned   COSC_LSB     = 12;
   localparam int unsigned   IRQ_BOR_BIT  = 0;
   localparam int unsigned   IRQ_CF_BIT   = 1;
   localparam int unsigned   IRQ_W        = 2;

   // ======================================================
   // oscillator groups and primary mode bits
   localparam logic [1:0]    GRP_SEC      = 2'h0;
   localparam logic [1:0]    GRP_FRC      = 2'h1;
   localparam logic [1:0]    GRP_INTERNAL_LOW_POWER_RC     = 2'h2;
   localparam logic [1:0]    GRP_PRI      = 2'h3;
   localparam int unsigned   PRI_XTAL_BIT = 3;
   localparam int unsigned   PRI_PLL_BIT  = 2;

   // configuration word, low twelve bits of the config register
   typedef struct packed {
      logic       power_up_delay_timer_en;
      logic       bor_en;
      logic [1:0] bor_level;
      logic [1:0] switch_monitor_cfg;
      logic [3:0] primary_osc_cfg;
      logic [1:0] osc_group_cfg;
   } cfg_s;

   localparam cfg_s CFG_RESET = '{power_up_delay_timer_en: 1'b1, bor_en: 1'b1,
      bor_level: 2'h0, switch_monitor_cfg: 2'h2,
      primary_osc_cfg: 4'h0, osc_group_cfg: GRP_FRC};

   // synchronised pin group
   typedef struct packed {
      logic [2:0] bor_trip;
      logic       pll_lock;
      logic       osc_running;
   } pins_s;

   // ======================================================
   // timing
   localparam int unsigned   CNT_W        = 20;
   localparam int unsigned   CLK_PERIOD_NS = 100;
   localparam int unsigned   POR_DELAY_NS = 10000;
   localparam int unsigned   POWER_UP_DELAY_TIMER_DELAY_NS = 64000000;
   localparam int unsigned   FSD_DELAY_NS = 100000;
   localparam logic [CNT_W-1:0] POR_CYC = CNT_W'(
      (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] POWER_UP_DELAY_TIMER_CYC_DEF = CNT_W'(
      (POWER_UP_DELAY_TIMER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] FSD_CYC = CNT_W'(
      (FSD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0]   OST_CYC      = 11'h400;

   typedef enum logic [2:0] {
      ST_LOAD, ST_DELAY, ST_FROZEN, ST_TRAP_SEL, ST_TRAP_FLAG,
      ST_TRAP_GO, ST_RUN
   } seq_state_e;

endpackage

/* core/reset_release_and_brownout_seq.sv */
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module reset_release_and_brownout_seq #(
   parameter logic [reset_seq_pkg::CNT_W-1:0] POWER_UP_CYCLES =
      reset_seq_pkg::POWER_UP_DELAY_TIMER_CYC_DEF
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_n_in,
   input  wire logic [reset_seq_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic [2:0]                 s_axi_awprot_in,
   input  wire logic                       s_axi_awvalid_in,
   output logic                            s_axi_awready_out,
   input  wire logic [31:0]                s_axi_wdata_in,
   input  wire logic [3:0]                 s_axi_wstrb_in,
   input  wire logic                       s_axi_wvalid_in,
   output logic                            s_axi_wready_out,
   output logic [1:0]                      s_axi_bresp_out,
   output logic                            s_axi_bvalid_out,
   input  wire logic                       s_axi_bready_in,
   input  wire logic [reset_seq_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic [2:0]                 s_axi_arprot_in,
   input  wire logic                       s_axi_arvalid_in,
   output logic                            s_axi_arready_out,
   output logic [31:0]                     s_axi_rdata_out,
   output logic [1:0]                      s_axi_rresp_out,
   output logic                            s_axi_rvalid_out,
   input  wire logic                       s_axi_rready_in,
   input  wire logic                       osc_running_in,
   input  wire logic                       pll_lock_in,
   input  wire logic [2:0]                 bor_trip_in,
   output logic                            internal_reset_n_out,
   output logic                            sys_clk_enable_out,
   output logic [1:0]                      clock_select_out,
   output logic                            clock_fail_trap_out,
   output logic                            brownout_reset_pulse_out,
   output logic                            irq_out
);
   import reset_seq_pkg::*;

   // ======================================================
   // helpers
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] off);
      reg_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   function automatic logic addr_known(input logic [ADDR_W-1:0] a);
      addr_known = reg_hit(a, RST_CTRL_OFF) | reg_hit(a, OSC_CTRL_OFF)
                 | reg_hit(a, CFG_OFF) | reg_hit(a, IRQ_STAT_OFF)
                 | reg_hit(a, IRQ_CLR_OFF) | reg_hit(a, IRQ_EN_OFF);
   endfunction

   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      apply_strb = r;
   endfunction

   // ======================================================
   // declarations
   pins_s                pin_meta_q;
   pins_s                pin_q;
   cfg_s                 cfg_q;
   seq_state_e           state_q;
   logic [CNT_W-1:0]     delay_q;
   logic [10:0]          ost_q;
   logic [1:0]           cosc_q;
   logic [1:0]           nosc_q;
   logic                 osc_switch_go_q;
   logic                 cf_q;
   logic                 por_flag_q;
   logic                 bor_flag_q;
   logic                 bor_low_q;
   logic                 bor_pulse_q;
   logic                 trap_q;
   logic [IRQ_W-1:0]     irq_stat_q;
   logic [IRQ_W-1:0]     irq_en_q;
   logic                 aw_full_q;
   logic [ADDR_W-1:0]    aw_addr_q;
   logic                 w_full_q;
   logic [31:0]          w_data_q;
   logic [3:0]           w_strb_q;
   logic                 bvalid_q;
   logic [1:0]           bresp_q;
   logic                 rvalid_q;
   logic [31:0]          rdata_q;
   logic [1:0]           rresp_q;
   logic                 do_write;
   logic                 monitor_en;
   logic                 switch_en;
   logic                 fast_exit;
   logic                 src_xtal;
   logic                 src_internal;
   logic                 uses_pll;
   logic                 running_ok;
   logic                 ost_done;
   logic                 clk_ok;
   logic [CNT_W-1:0]     target;
   logic                 delay_done;
   logic [1:0]           bor_sel;
   logic                 bor_low;
   logic                 bor_rise;
   logic [31:0]          rd_word;
   logic [31:0]          cfg_wr;

   // ======================================================
   // pin synchronisers, two flops each
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_meta_q <= '0;
         pin_q      <= '0;
      end else begin
         pin_meta_q <= '{bor_trip: bor_trip_in, pll_lock: pll_lock_in,
                         osc_running: osc_running_in};
         pin_q      <= pin_meta_q;
      end
   end

   // ======================================================
   // clock source qualification
   always_comb begin
      monitor_en   = (cfg_q.switch_monitor_cfg == 2'h0);
      switch_en    = !cfg_q.switch_monitor_cfg[1];
      fast_exit    = !monitor_en && !cfg_q.power_up_delay_timer_en;
      src_xtal     = (cosc_q == GRP_SEC) || ((cosc_q == GRP_PRI) &&
                     cfg_q.primary_osc_cfg[PRI_XTAL_BIT]);
      src_internal = (cosc_q == GRP_FRC) || (cosc_q == GRP_INTERNAL_LOW_POWER_RC);
      uses_pll     = (cosc_q == GRP_PRI) &&
                     cfg_q.primary_osc_cfg[PRI_PLL_BIT];
      running_ok   = src_internal || (fast_exit && !src_xtal)
                     || pin_q.osc_running;
      ost_done     = !src_xtal || (ost_q == OST_CYC);
      clk_ok       = running_ok && ost_done &&
                     (!uses_pll || pin_q.pll_lock);
   end

   // release target: power-on plus power-up or fail-safe delay, else power-on alone
   always_comb begin
      if (cfg_q.power_up_delay_timer_en) begin
         target = POR_CYC + POWER_UP_CYCLES;
      end else if (src_xtal && !fast_exit) begin
         target = POR_CYC + FSD_CYC;
      end else begin
         target = POR_CYC;
      end
      delay_done = (delay_q >= target);
   end

   // brownout compare on the selected trip level, sleep does not gate it
   always_comb begin
      bor_sel  = (cfg_q.bor_level == 2'h3) ? 2'h2 : cfg_q.bor_level;
      bor_low  = cfg_q.bor_en && pin_q.bor_trip[bor_sel];
      bor_rise = bor_low && !bor_low_q;
   end

   // ======================================================
   // reset release sequencer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ST_LOAD;
         delay_q <= '0;
      end else if (bor_low) begin
         state_q <= ST_LOAD;
         delay_q <= '0;
      end else begin
         case (state_q)
            ST_LOAD: begin
               state_q <= ST_DELAY;
               delay_q <= '0;
            end
            ST_DELAY: begin
               if (!delay_done) begin
                  delay_q <= delay_q + 1'b1;
               end else if (clk_ok) begin
                  state_q <= ST_RUN;
               end else if (monitor_en) begin
                  state_q <= ST_TRAP_SEL;
               end else begin
                  state_q <= ST_FROZEN;
               end
            end
            ST_FROZEN: begin
               if (clk_ok) begin
                  state_q <= ST_RUN;
               end
            end
            ST_TRAP_SEL:  state_q <= ST_TRAP_FLAG;
            ST_TRAP_FLAG: state_q <= ST_TRAP_GO;
            ST_TRAP_GO:   state_q <= ST_RUN;
            ST_RUN: begin
               if (monitor_en && !clk_ok) begin
                  state_q <= ST_TRAP_SEL;
               end
            end
            default: state_q <= ST_LOAD;
         endcase
      end
   end

   // start-up timer counts running crystal cycles
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ost_q <= '0;
      end else if (state_q == ST_LOAD || !pin_q.osc_running) begin
         ost_q <= '0;
      end else if (src_xtal && ost_q != OST_CYC) begin
         ost_q <= ost_q + 1'b1;
      end
   end

   // ======================================================
   // oscillator control: groups, fail flag, switch go
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cosc_q  <= GRP_FRC;
         nosc_q  <= GRP_FRC;
         osc_switch_go_q <= 1'b0;
         cf_q    <= 1'b0;
      end else if (state_q == ST_LOAD) begin
         cosc_q  <= cfg_q.osc_group_cfg;
         nosc_q  <= cfg_q.osc_group_cfg;
         osc_switch_go_q <= 1'b0;
         cf_q    <= 1'b0;
      end else if (state_q == ST_TRAP_SEL) begin
         cosc_q <= GRP_FRC;
      end else if (state_q == ST_TRAP_FLAG) begin
         cf_q <= 1'b1;
      end else if (state_q == ST_TRAP_GO) begin
         osc_switch_go_q <= 1'b0;
      end else if (do_write && reg_hit(aw_addr_q, OSC_CTRL_OFF)) begin
         if (w_strb_q[1]) begin
            nosc_q <= w_data_q[NOSC_LSB +: 2];
         end
         if (w_strb_q[0]) begin
            osc_switch_go_q <= w_data_q[OSC_SWITCH_GO_BIT] && switch_en;
            cf_q    <= cf_q && w_data_q[CF_BIT];
         end
      end else if (osc_switch_go_q) begin
         cosc_q  <= nosc_q;
         osc_switch_go_q <= 1'b0;
      end
   end

   // ======================================================
   // reset flags, brownout pulse, trap pulse
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         por_flag_q  <= 1'b1;
         bor_flag_q  <= 1'b0;
         bor_low_q   <= 1'b0;
         bor_pulse_q <= 1'b0;
         trap_q      <= 1'b0;
      end else begin
         bor_low_q   <= bor_low;
         bor_pulse_q <= bor_rise;
         trap_q      <= (state_q == ST_TRAP_GO);
         if (bor_rise) begin
            bor_flag_q <= 1'b1;
         end else if (do_write && reg_hit(aw_addr_q, RST_CTRL_OFF) &&
                      w_strb_q[0]) begin
            bor_flag_q <= bor_flag_q && w_data_q[BOR_FLAG_BIT];
         end
         if (do_write && reg_hit(aw_addr_q, RST_CTRL_OFF) &&
             w_strb_q[0]) begin
            por_flag_q <= por_flag_q && w_data_q[POR_FLAG_BIT];
         end
      end
   end

   // configuration register, only the low twelve bits are kept
   assign cfg_wr = apply_strb({20'h0, cfg_q}, w_data_q, w_strb_q);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_q <= CFG_RESET;
      end else if (do_write && reg_hit(aw_addr_q, CFG_OFF)) begin
         cfg_q <= cfg_s'(cfg_wr[11:0]);
      end
   end

   // interrupt status (set wins), clear and enable
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_stat_q <= '0;
         irq_en_q   <= '0;
      end else begin
         if (do_write && reg_hit(aw_addr_q, IRQ_CLR_OFF) && w_strb_q[0]) begin
            irq_stat_q <= irq_stat_q & ~w_data_q[IRQ_W-1:0];
         end
         if (bor_rise) begin
            irq_stat_q[IRQ_BOR_BIT] <= 1'b1;
         end
         if (state_q == ST_TRAP_SEL) begin
            irq_stat_q[IRQ_CF_BIT] <= 1'b1;
         end
         if (do_write && reg_hit(aw_addr_q, IRQ_EN_OFF) && w_strb_q[0]) begin
            irq_en_q <= w_data_q[IRQ_W-1:0];
         end
      end
   end

   // ======================================================
   // axi4-lite write channel
   assign do_write = aw_full_q && w_full_q && !bvalid_q;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
         w_full_q  <= 1'b0;
         w_data_q  <= '0;
         w_strb_q  <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in;
         end else if (do_write) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
         end else if (do_write) begin
            w_full_q <= 1'b0;
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= addr_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read data selection
   always_comb begin
      rd_word = '0;
      if (reg_hit(s_axi_araddr_in, RST_CTRL_OFF)) begin
         rd_word[POR_FLAG_BIT] = por_flag_q;
         rd_word[BOR_FLAG_BIT] = bor_flag_q;
      end else if (reg_hit(s_axi_araddr_in, OSC_CTRL_OFF)) begin
         rd_word[COSC_LSB +: 2] = cosc_q;
         rd_word[NOSC_LSB +: 2] = nosc_q;
         rd_word[LOCK_BIT]      = pin_q.pll_lock;
         rd_word[CF_BIT]        = cf_q;
         rd_word[OSC_SWITCH_GO_BIT]     = osc_switch_go_q;
      end else if (reg_hit(s_axi_araddr_in, CFG_OFF)) begin
         rd_word[11:0] = cfg_q;
      end else if (reg_hit(s_axi_araddr_in, IRQ_STAT_OFF)) begin
         rd_word[IRQ_W-1:0] = irq_stat_q;
      end else if (reg_hit(s_axi_araddr_in, IRQ_EN_OFF)) begin
         rd_word[IRQ_W-1:0] = irq_en_q;
      end
   end

   // axi4-lite read channel
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= addr_known(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_in) begin
         rvalid_q <= 1'b0;
      end
   end

   // ======================================================
   // outputs
   assign s_axi_awready_out = !aw_full_q && !bvalid_q;
   assign s_axi_wready_out  = !w_full_q && !bvalid_q;
   assign s_axi_bvalid_out  = bvalid_q;
   assign s_axi_bresp_out   = bresp_q;
   assign s_axi_arready_out = !rvalid_q;
   assign s_axi_rvalid_out  = rvalid_q;
   assign s_axi_rdata_out   = rdata_q;
   assign s_axi_rresp_out   = rresp_q;
   assign internal_reset_n_out = (state_q == ST_RUN) ||
      (state_q == ST_TRAP_SEL) || (state_q == ST_TRAP_FLAG) ||
      (state_q == ST_TRAP_GO);
   assign sys_clk_enable_out = internal_reset_n_out && clk_ok;
   assign clock_select_out  = cosc_q;
   assign clock_fail_trap_out = trap_q;
   assign brownout_reset_pulse_out = bor_pulse_q;
   assign irq_out = |(irq_stat_q & irq_en_q);

   // ======================================================
   // assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   trap_on_fail_a: assert property (
      (state_q == ST_DELAY && delay_done && monitor_en && !clk_ok &&
       !bor_low) |=> state_q == ST_TRAP_SEL)
      else $error("clock failure after delays raised no trap");
   frc_order_a: assert property (disable iff (!rst_n_in || bor_low)
      (state_q == ST_TRAP_SEL) |=> cosc_q == GRP_FRC ##1 cf_q
      ##1 (!osc_switch_go_q && cosc_q == GRP_FRC))
      else $error("fail switch sequence wrong");
   fast_exit_a: assert property (
      fast_exit |-> target == POR_CYC)
      else $error("fast exit still adds delay");
   immediate_src_a: assert property (
      (fast_exit && !src_xtal) |-> running_ok)
      else $error("non-crystal source not running at fast exit");
   frozen_hold_a: assert property (
      (state_q == ST_FROZEN) |-> (!internal_reset_n_out &&
       !sys_clk_enable_out))
      else $error("frozen state leaked out of reset");
   bor_reset_a: assert property (
      bor_rise |=> (brownout_reset_pulse_out && bor_flag_q &&
       state_q == ST_LOAD && !internal_reset_n_out))
      else $error("brownout did not reset and flag");
   bor_off_a: assert property (
      !cfg_q.bor_en |=> !brownout_reset_pulse_out)
      else $error("brownout pulse while disabled");
   xtal_hold_a: assert property (
      (src_xtal && ost_q != OST_CYC) |-> !sys_clk_enable_out)
      else $error("clock released before startup timer");
   pll_hold_a: assert property (
      (uses_pll && !pin_q.pll_lock) |-> !sys_clk_enable_out)
      else $error("clock released before pll lock");
   release_time_a: assert property (
      $rose(internal_reset_n_out) |-> $past(delay_done))
      else $error("reset released before delays elapsed");
   load_cfg_a: assert property (
      (state_q == ST_LOAD) |=> (cosc_q == $past(cfg_q.osc_group_cfg) &&
       nosc_q == $past(cfg_q.osc_group_cfg)))
      else $error("groups not loaded from configuration");
   monitor_off_a: assert property (
      cfg_q.switch_monitor_cfg[1] |=> state_q != ST_TRAP_SEL)
      else $error("trap taken with monitor disabled");

   trap_path_c: cover property (state_q == ST_TRAP_SEL ##3 state_q == ST_RUN);
   frozen_exit_c: cover property (state_q == ST_FROZEN ##1 state_q == ST_RUN);
   bor_event_c: cover property (bor_rise ##1 brownout_reset_pulse_out);
   fast_release_c: cover property (fast_exit && $rose(internal_reset_n_out));

endmodule
`default_nettype wire

/* sim/reset_release_and_brownout_seq_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module reset_release_and_brownout_seq_tb;
   import reset_seq_pkg::*;
   // ======================================================
   // stimulus, observation and counters
   logic        clk, rst_n, awv, wv, bre, arv, rre, osc, pll;
   logic [7:0]  awa, ara;
   logic [31:0] wd;
   logic [2:0]  trip;
   logic        awr, wr, bv, arr, rv, rel_n, cken, trap, borp, irq;
   logic [1:0]  br, rr, csel, g;
   logic [31:0] rd;
   int          n_fail, cmp_count, n_bor, n_trap, t, nb, nt;
   reset_release_and_brownout_seq #(.POWER_UP_CYCLES(20'd20)) dut (
      .clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awa),
      .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(br),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_araddr_in(ara),
      .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .osc_running_in(osc),
      .pll_lock_in(pll), .bor_trip_in(trip), .internal_reset_n_out(rel_n),
      .sys_clk_enable_out(cken), .clock_select_out(csel),
      .clock_fail_trap_out(trap), .brownout_reset_pulse_out(borp),
      .irq_out(irq));
   // ======================================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // write on both channels; handshakes seen at the negedge before the edge
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      logic ha, hw, hb;
      logic [1:0] hr;
      int k;
      hb = 1'b0;
      k = 0;
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
      while (!hb && k < 40) begin
         @(negedge clk);
         ha = awv & awr; hw = wv & wr; hb = bv; hr = br;
         @(posedge clk);
         if (ha) awv <= 1'b0;
         if (hw) wv <= 1'b0;
         k++;
      end
      bre <= 1'b0;
      @(posedge clk);
      chk({hb, hr}, {1'b1, er});
   endtask
   // read one word and compare the masked data and the response
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e, input logic [1:0] er);
      logic hv, ha;
      logic [1:0] hr;
      logic [31:0] hd;
      int k;
      hv = 1'b0;
      k = 0;
      ara <= a; arv <= 1'b1; rre <= 1'b1;
      while (!hv && k < 40) begin
         @(negedge clk);
         ha = arv & arr; hv = rv; hr = rr; hd = rd;
         @(posedge clk);
         if (ha) arv <= 1'b0;
         k++;
      end
      rre <= 1'b0;
      @(posedge clk);
      chk({hv, hr}, {1'b1, er});
      chk(hd & m, e);
   endtask
   // wait for the internal reset to let go, counting cycles into t
   task automatic wait_rel(input int n);
      t = 0;
      while (rel_n !== 1'b1 && t < n) begin
         @(negedge clk);
         t++;
      end
      @(posedge clk);
   endtask
   task automatic bor_hit(input int l);
      trip <= 3'h1 << l;
      repeat (5) @(posedge clk);
      chk(rel_n, 1'b0);
      trip <= 3'h0;
   endtask
   task automatic end_of_test();
      if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // clock, pulse counters and watchdog
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(negedge clk) begin
      if (borp === 1'b1) n_bor++;
      if (trap === 1'b1) n_trap++;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
   // ======================================================
   // main sequence
   initial begin
      rst_n = 1'b0; awv = 1'b0; wv = 1'b0; bre = 1'b0; arv = 1'b0;
      rre = 1'b0; osc = 1'b1; pll = 1'b1; trip = 3'h0; awa = 8'h00;
      ara = 8'h00; wd = 32'h0; n_fail = 0; cmp_count = 0; n_bor = 0;
      n_trap = 0;
      t = $urandom(73);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (100) @(posedge clk);
      chk(rel_n, 1'b0);
      wait_rel(100);
      chk({rel_n, cken, csel}, {2'h3, GRP_FRC});
      rd_chk(RST_CTRL_OFF, 32'h3, 32'h1, RESP_OKAY);
      rd_chk(CFG_OFF, 32'hFFF, 32'hC81, RESP_OKAY);
      rd_chk(OSC_CTRL_OFF, 32'h3329, 32'h1120, RESP_OKAY);
      rd_chk(8'h40, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
      wr_reg(8'h40, 32'h1, RESP_SLVERR);
      g = 2'($urandom);
      wr_reg(OSC_CTRL_OFF, {22'h0, g, 8'h00}, RESP_OKAY);
      rd_chk(OSC_CTRL_OFF, 32'h300, {22'h0, g, 8'h00}, RESP_OKAY);
      for (int l = 0; l < 3; l++) begin
         nb = n_bor;
         wr_reg(CFG_OFF, 32'hC81 | (l << 8), RESP_OKAY);
         trip <= ~(3'h1 << l);
         repeat (8) @(posedge clk);
         chk(n_bor, nb);
         bor_hit(l);
         wait_rel(300);
         chk({rel_n, 32'(n_bor)}, {1'b1, 32'(nb + 1)});
      end
      rd_chk(RST_CTRL_OFF, 32'h2, 32'h2, RESP_OKAY);
      rd_chk(OSC_CTRL_OFF, 32'h300, 32'h100, RESP_OKAY);
      chk(irq, 1'b0);
      wr_reg(IRQ_EN_OFF, 32'h3, RESP_OKAY);
      chk(irq, 1'b1);
      wr_reg(IRQ_CLR_OFF, 32'h1, RESP_OKAY);
      chk(irq, 1'b0);
      osc <= 1'b0;
      wr_reg(CFG_OFF, 32'hC23, RESP_OKAY);
      nt = n_trap;
      bor_hit(0);
      wait_rel(400);
      repeat (5) @(posedge clk);
      chk({rel_n, csel, 32'(n_trap)}, {1'b1, GRP_FRC, 32'(nt + 1)});
      rd_chk(OSC_CTRL_OFF, 32'h3009, 32'h1008, RESP_OKAY);
      rd_chk(IRQ_STAT_OFF, 32'h2, 32'h2, RESP_OKAY);
      wr_reg(CFG_OFF, 32'hCA3, RESP_OKAY);
      nt = n_trap;
      bor_hit(0);
      repeat (300) @(posedge clk);
      chk({rel_n, cken, 32'(n_trap)}, {2'h0, 32'(nt)});
      osc <= 1'b1;
      wait_rel(1400);
      chk({rel_n, 1'(t > 1000), csel}, {2'h3, GRP_PRI});
      osc <= 1'b0;
      wr_reg(CFG_OFF, 32'h483, RESP_OKAY);
      bor_hit(0);
      wait_rel(400);
      chk({rel_n, 1'(t < 115), cken}, 3'h7);
      end_of_test();
   end
endmodule
`default_nettype wire
